// >>> hdl/see_filter.sv
// Synchroniser and glitch filter for one bus input
`timescale 1ns/1ps
`include "see_map.svh"
module see_filter #(
    parameter int WIDTH_CYC = `SEE_GLITCH_CYC
) (
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic en_in,
    // Raw and filtered line
    input  wire logic pin_in,
    output logic      line_out
);
    logic       s1_q, s2_q, s1_d, s2_d, line_d;
    logic [7:0] cnt_q, cnt_d;
    always_comb begin
        s1_d   = pin_in;
        s2_d   = s1_q;
        cnt_d  = 8'h00;
        line_d = line_out;
        if (s2_q != line_out) begin
            cnt_d = cnt_q + 8'h01;
            if (cnt_q >= 8'(WIDTH_CYC - 1)) begin
                line_d = s2_q;
                cnt_d  = 8'h00;
            end
        end
    end
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s1_q     <= 1'b1;
            s2_q     <= 1'b1;
            cnt_q    <= 8'h00;
            line_out <= 1'b1;
        end else if (en_in) begin
            s1_q     <= s1_d;
            s2_q     <= s2_d;
            cnt_q    <= cnt_d;
            line_out <= line_d;
        end
    end
    a_filter_hold: assert property (@(posedge clk_in) disable iff (rst_in)
        en_in && (s2_q == line_out) |=> $stable(line_out))
        else $error("filtered line moved without input change");
endmodule

// >>> hdl/see_target.sv
// Two-wire EEPROM target core: init, traps, page writes
`timescale 1ns/1ps
`include "see_map.svh"
module see_target #(
    parameter int INIT_CYC   = `SEE_INIT_CYC,
    parameter int PAGE_BYTES = `SEE_PAGE_BYTES,
    parameter int MEM_WORDS  = `SEE_MEM_WORDS,
    parameter logic [3:0] DEV_CODE = `SEE_DEV_CODE // Arbitrary value
) (
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       en_in,
    // Bus pins
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_out,
    // Supply monitor
    input  wire logic       low_vcc_in,
    // Status
    output logic            ready_out,
    output logic            prog_out,
    output logic [9:0]      prog_addr_out,
    output logic [7:0]      prog_data_out
);
    localparam int PW = (PAGE_BYTES == 8) ? 3 : 4;
    localparam int GW = (`SEE_GLITCH_CYC);
    logic scl_f, sda_f, scl_p_q, sda_p_q, lv1_q, lv2_q;
    see_filter #(.WIDTH_CYC(GW)) u_scl (.clk_in(clk_in), .rst_in(rst_in),
        .en_in(en_in), .pin_in(scl_in), .line_out(scl_f));
    see_filter #(.WIDTH_CYC(GW)) u_sda (.clk_in(clk_in), .rst_in(rst_in),
        .en_in(en_in), .pin_in(sda_in), .line_out(sda_f));
    logic start_w, stop_w, rise_w, fall_w;
    assign start_w = scl_f && scl_p_q && sda_p_q && !sda_f;
    assign stop_w  = scl_f && scl_p_q && !sda_p_q && sda_f;
    assign rise_w  = scl_f && !scl_p_q;
    assign fall_w  = !scl_f && scl_p_q;

    see_pkg::see_state_t st_q, st_d, ret_q, ret_d;
    logic [31:0] init_q, init_d;
    logic [3:0]  bit_q, bit_d;
    logic [7:0]  sh_q, sh_d;
    logic [9:0]  adr_q, adr_d;
    logic [7:0]  buf_q [PAGE_BYTES];
    logic [7:0]  buf_d [PAGE_BYTES];
    logic [4:0]  nb_q, nb_d;
    logic        ack_q, ack_d, pend_q, pend_d;
    logic        prog_d;
    logic [4:0]  pi_q, pi_d;
    logic [9:0]  pa_q, pa_d;
    logic [7:0]  pdat_d;
    logic [9:0]  paddr_d;

    always_comb begin
        st_d   = st_q;
        ret_d  = ret_q;
        init_d = init_q;
        bit_d  = bit_q;
        sh_d   = sh_q;
        adr_d  = adr_q;
        buf_d  = buf_q;
        nb_d   = nb_q;
        ack_d  = ack_q;
        pend_d = pend_q;
        prog_d = 1'b0;
        pi_d   = pi_q;
        pa_d   = pa_q;
        pdat_d = prog_data_out;
        paddr_d = prog_addr_out;
        if (pend_q) begin
            // Programs captured bytes one per cycle
            prog_d = 1'b1;
            pdat_d = buf_q[pa_q[PW-1:0]];
            paddr_d = pa_q;
            pa_d   = {adr_q[9:PW], pa_q[PW-1:0] + PW'(1)};
            pi_d   = pi_q + 5'h01;
            if (pi_q + 5'h01 >= nb_q) begin
                pend_d = 1'b0;
            end
        end
        case (st_q)
            see_pkg::SEE_INIT: begin
                if (init_q >= 32'(INIT_CYC - 1)) begin
                    st_d = see_pkg::SEE_IDLE;
                end else begin
                    init_d = init_q + 32'h1;
                end
            end
            default: begin
                if (start_w) begin
                    // Start always resyncs to the address phase
                    st_d  = see_pkg::SEE_DEVA;
                    bit_d = 4'h0;
                    ack_d = 1'b0;
                    nb_d  = pend_q ? nb_q : 5'h00;
                end else if (stop_w) begin
                    st_d  = see_pkg::SEE_IDLE;
                    ack_d = 1'b0;
                    // Partial byte dropped, full bytes kept
                    if (nb_q != 5'h00 && !lv2_q && !pend_q) begin
                        pend_d = 1'b1;
                        pi_d   = 5'h00;
                        pa_d   = {adr_q[9:PW],
                                  adr_q[PW-1:0] - nb_q[PW-1:0]};
                    end else if (!pend_q) begin
                        nb_d = 5'h00;
                    end
                end else if (st_q != see_pkg::SEE_IDLE) begin
                    if (rise_w && st_q != see_pkg::SEE_ACK) begin
                        sh_d  = {sh_q[6:0], sda_f};
                        bit_d = bit_q + 4'h1;
                    end
                    if (fall_w) begin
                        if (st_q == see_pkg::SEE_ACK) begin
                            ack_d = 1'b0;
                            st_d  = ret_q;
                            bit_d = 4'h0;
                        end else if (bit_q == 4'h8) begin
                            bit_d = 4'h0;
                            case (st_q)
                                see_pkg::SEE_DEVA: begin
                                    if (sh_q[7:4] == DEV_CODE && !sh_q[0] &&
                                        !pend_q) begin
                                        adr_d[9:8] = sh_q[2:1];
                                        ack_d = 1'b1;
                                        st_d  = see_pkg::SEE_ACK;
                                        ret_d = see_pkg::SEE_WADR;
                                    end else begin
                                        st_d = see_pkg::SEE_SKIP;
                                    end
                                end
                                see_pkg::SEE_WADR: begin
                                    adr_d[7:0] = sh_q;
                                    ack_d = 1'b1;
                                    st_d  = see_pkg::SEE_ACK;
                                    ret_d = see_pkg::SEE_WDAT;
                                end
                                see_pkg::SEE_WDAT: begin
                                    buf_d[adr_q[PW-1:0]] = sh_q;
                                    // Wrap inside the page
                                    adr_d = {adr_q[9:PW],
                                             adr_q[PW-1:0] + PW'(1)};
                                    if (nb_q < 5'(PAGE_BYTES)) begin
                                        nb_d = nb_q + 5'h01;
                                    end
                                    ack_d = 1'b1;
                                    st_d  = see_pkg::SEE_ACK;
                                    ret_d = see_pkg::SEE_WDAT;
                                end
                                default: st_d = see_pkg::SEE_SKIP;
                            endcase
                        end
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_q    <= see_pkg::SEE_INIT;
            ret_q   <= see_pkg::SEE_IDLE;
            init_q  <= 32'h0;
            bit_q   <= 4'h0;
            sh_q    <= 8'h00;
            adr_q   <= 10'h000;
            nb_q    <= 5'h00;
            ack_q   <= 1'b0;
            pend_q  <= 1'b0;
            pi_q    <= 5'h00;
            pa_q    <= 10'h000;
            prog_out <= 1'b0;
            prog_data_out <= 8'h00;
            prog_addr_out <= 10'h000;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
            lv1_q   <= 1'b0;
            lv2_q   <= 1'b0;
            for (int i = 0; i < PAGE_BYTES; i++) begin
                buf_q[i] <= 8'h00;
            end
        end else if (en_in) begin
            st_q    <= st_d;
            ret_q   <= ret_d;
            init_q  <= init_d;
            bit_q   <= bit_d;
            sh_q    <= sh_d;
            adr_q   <= adr_d;
            nb_q    <= nb_d;
            ack_q   <= ack_d;
            pend_q  <= pend_d;
            pi_q    <= pi_d;
            pa_q    <= pa_d;
            prog_out <= prog_d;
            prog_data_out <= pdat_d;
            prog_addr_out <= paddr_d;
            scl_p_q <= scl_f;
            sda_p_q <= sda_f;
            lv1_q   <= low_vcc_in;
            lv2_q   <= lv1_q;
            buf_q   <= buf_d;
        end
    end

    assign sda_out       = 1'b0;
    assign sda_oe_out    = ack_q;
    assign ready_out     = (st_q != see_pkg::SEE_INIT);

    a_init_quiet: assert property (@(posedge clk_in) disable iff (rst_in)
        !ready_out |-> !sda_oe_out && !pend_q)
        else $error("activity during init");
    a_init_idle: assert property (@(posedge clk_in) disable iff (rst_in)
        $rose(ready_out) |-> st_q == see_pkg::SEE_IDLE)
        else $error("init did not end in standby");
    a_stop_idle: assert property (@(posedge clk_in) disable iff (rst_in)
        en_in && ready_out && stop_w |=> st_q == see_pkg::SEE_IDLE)
        else $error("stop did not return to standby");
    a_start_sync: assert property (@(posedge clk_in) disable iff (rst_in)
        en_in && ready_out && start_w |=>
        st_q == see_pkg::SEE_DEVA && bit_q == 4'h0)
        else $error("start did not resync");
    a_abort_empty: assert property (@(posedge clk_in) disable iff (rst_in)
        en_in && ready_out && stop_w && nb_q == 5'h00 && !pend_q
        |=> !pend_q)
        else $error("write started with no full byte");
    a_lowv_cancel: assert property (@(posedge clk_in) disable iff (rst_in)
        en_in && ready_out && stop_w && lv2_q && !pend_q |=> !pend_q)
        else $error("write not cancelled at low supply");
    a_page_wrap: assert property (@(posedge clk_in) disable iff (rst_in)
        prog_out |-> prog_addr_out[9:PW] == adr_q[9:PW])
        else $error("program left the page");
    a_addr_inc: assert property (@(posedge clk_in) disable iff (rst_in)
        en_in && st_q == see_pkg::SEE_WDAT && fall_w && bit_q == 4'h8 &&
        !start_w && !stop_w |=>
        adr_q[PW-1:0] == $past(adr_q[PW-1:0]) + PW'(1))
        else $error("address not incremented after byte");
    a_prog_count: assert property (@(posedge clk_in) disable iff (rst_in)
        $fell(pend_q) |-> $past(pi_q) + 5'h01 >= nb_q)
        else $error("program ended early");
    c_ready: cover property (@(posedge clk_in) $rose(ready_out));
    c_ack: cover property (@(posedge clk_in) $rose(sda_oe_out));
    c_prog: cover property (@(posedge clk_in) $rose(prog_out));
    c_abort: cover property (@(posedge clk_in)
        ready_out && stop_w && st_q == see_pkg::SEE_WDAT);
endmodule

// >>> shared/see_map.svh
// Constants for the serial EEPROM write-trap target
// Summary of operation
// - During power-on init interval every bus instruction is ignored.
// - After init completes the device idles in standby awaiting a start.
// - Resync reset sequence leaves the same state as power-on init.
// - Start seen mid-transfer abandons it and resyncs to the device address phase; stop returns to standby.
// - Both inputs are filtered so pulses of 160 ns or less vanish.
// - Stop before eight data bits aborts the write, nothing programmed.
// - Stop after full page bytes programs those bytes, drops partial bits.
// - Page write past page size wraps inside the page only.
// - Address counter increments on clock fall of each eighth data bit.
// - With low supply active a pending write is cancelled at stop.
`ifndef SEE_MAP_SVH
`define SEE_MAP_SVH
`define SEE_CLK_HZ        25000000
`define SEE_INIT_NS       100000
`define SEE_INIT_CYC      ((`SEE_INIT_NS * 25) / 1000)
`define SEE_GLITCH_NS     160
`define SEE_GLITCH_CYC    (((`SEE_GLITCH_NS * 25) + 999) / 1000 + 1)
`define SEE_PAGE_BYTES    16
`define SEE_MEM_WORDS     1024
`define SEE_DEV_CODE      4'hA
`endif

// >>> shared/see_pkg.sv
// Types for the serial EEPROM write-trap target
package see_pkg;
    typedef enum logic [2:0] {
        SEE_INIT  = 3'h0,
        SEE_IDLE  = 3'h1,
        SEE_DEVA  = 3'h2,
        SEE_WADR  = 3'h3,
        SEE_WDAT  = 3'h4,
        SEE_ACK   = 3'h5,
        SEE_SKIP  = 3'h6
    } see_state_t;
endpackage

// >>> verif/see_ctrl_model.sv
// Bus controller model for the two-wire target
`timescale 1ns/1ps
module see_ctrl_model #(
    parameter int Q = 12
) (
    // Clock and wire level
    input  wire logic clk_in,
    input  wire logic sda_in,
    // Driven lines, high means released
    output logic      scl_out,
    output logic      sda_out
);
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    // Data moves one drive step (Q cycles, a third of the bit period) after clock fall
    task automatic drv(input logic c, input logic d);
        scl_out = c;
        sda_out = d;
        wt(Q);
    endtask
    task automatic start();
        drv(scl_out, 1'b1);
        drv(1'b1, 1'b1);
        drv(1'b1, 1'b0);
        drv(1'b0, 1'b0);
    endtask
    task automatic stop();
        drv(1'b0, 1'b0);
        drv(1'b1, 1'b0);
        drv(1'b1, 1'b1);
    endtask
    task automatic bit_tx(input logic b, output logic s);
        drv(1'b0, b);
        drv(1'b1, b);
        s = sda_in;
        drv(1'b0, b);
    endtask
    task automatic bits_tx(input logic [7:0] d, input int n);
        logic s;
        for (int i = 7; i > 7 - n; i--) bit_tx(d[i], s);
    endtask
    task automatic byte_tx(input logic [7:0] d, output logic ack);
        logic s;
        bits_tx(d, 8);
        bit_tx(1'b1, s);
        ack = ~s;
    endtask
    // Start, nine clocks with data high, start, stop
    task automatic resync();
        logic s;
        start();
        repeat (9) bit_tx(1'b1, s);
        start();
        stop();
    endtask
    // Short clock pulse while the clock is low
    task automatic glitch(input int n);
        scl_out = 1'b1;
        wt(n);
        drv(1'b0, sda_out);
    endtask
endmodule

// >>> verif/test_see_target.sv
// Self-checking bench for the two-wire EEPROM target
`timescale 1ns/1ps
`define CHK(a, b, m) begin compares++; if ((a) !== (b)) begin \
    mismatches++; $display("CHECK FAILED %0t %s", $time, m); end end
module test_see_target;
    logic       clk_in = 1'b0;
    logic       rst_in = 1'b1;
    logic       en_in = 1'b1;
    logic       low_vcc_in = 1'b0;
    logic       scl, sda_drv, sda_w, ack;
    logic       sda_out, sda_oe_out, ready_out, prog_out;
    logic [9:0] prog_addr_out;
    logic [7:0] prog_data_out;
    logic [9:0] pa[$];
    logic [7:0] pd[$];
    logic [7:0] ex[int];
    int         mismatches = 0;
    int         compares = 0;
    assign sda_w = sda_drv & (sda_oe_out ? sda_out : 1'b1);
    always #20 clk_in = ~clk_in;
    see_target #(.INIT_CYC(600), .PAGE_BYTES(16)) see_target_inst (
        .clk_in(clk_in), .rst_in(rst_in), .en_in(en_in),
        .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
        .sda_oe_out(sda_oe_out), .low_vcc_in(low_vcc_in),
        .ready_out(ready_out), .prog_out(prog_out),
        .prog_addr_out(prog_addr_out), .prog_data_out(prog_data_out));
    see_ctrl_model see_ctrl_model_inst (.clk_in(clk_in), .sda_in(sda_w),
        .scl_out(scl), .sda_out(sda_drv));
    always @(negedge clk_in) begin
        if (prog_out === 1'b1) begin
            pa.push_back(prog_addr_out);
            pd.push_back(prog_data_out);
        end
    end
    task automatic tally_and_finish();
        if (mismatches == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic wr(input logic [9:0] a, input int n, input int part,
                      input logic [7:0] base, input bit g, input bit ab);
        see_ctrl_model_inst.start();
        see_ctrl_model_inst.byte_tx({4'hA, 1'b0, a[9:8], 1'b0}, ack);
        `CHK(ack, 1'b1, "device address not answered")
        see_ctrl_model_inst.byte_tx(a[7:0], ack);
        if (g) see_ctrl_model_inst.glitch(4);
        for (int i = 0; i < n; i++) begin
            see_ctrl_model_inst.byte_tx(base + 8'(i), ack);
        end
        if (part > 0) see_ctrl_model_inst.bits_tx(8'h5A, part);
        if (ab) see_ctrl_model_inst.start();
        see_ctrl_model_inst.stop();
        see_ctrl_model_inst.wt(60);
    endtask
    task automatic chk(input logic [9:0] a, input int n,
                       input logic [7:0] base, input int kept);
        ex.delete();
        for (int i = 0; i < n; i++) ex[{a[9:4], 4'(a[3:0] + i)}] = base + 8'(i);
        `CHK(pa.size(), kept, "programmed byte count")
        foreach (pa[k]) begin
            `CHK(ex.exists(pa[k]) ? ex[pa[k]] : 8'hXX, pd[k], "byte data")
        end
        pa.delete();
        pd.delete();
    endtask
    task automatic s_init();
        see_ctrl_model_inst.start();
        see_ctrl_model_inst.byte_tx(8'hA0, ack);
        `CHK(ack, 1'b0, "answered during init")
        `CHK(ready_out, 1'b0, "ready during init")
        see_ctrl_model_inst.stop();
        for (int i = 0; i < 2000 && ready_out !== 1'b1; i++) begin
            see_ctrl_model_inst.wt(1);
        end
        `CHK(ready_out, 1'b1, "not ready after init")
        if (ready_out !== 1'b1) tally_and_finish();
        chk(10'h000, 0, 8'h00, 0);
    endtask
    task automatic s_page();
        wr(10'h123, 3, 4, 8'h40, 1'b0, 1'b0);
        chk(10'h123, 3, 8'h40, 3);
    endtask
    task automatic s_partial();
        wr(10'h200, 0, 5, 8'h00, 1'b0, 1'b0);
        chk(10'h200, 0, 8'h00, 0);
    endtask
    task automatic s_wrap();
        wr(10'h3F5, 17, 0, 8'h80, 1'b0, 1'b0);
        chk(10'h3F5, 17, 8'h80, 16);
    endtask
    task automatic s_abort();
        wr(10'h0A0, 1, 4, 8'h11, 1'b0, 1'b1);
        chk(10'h0A0, 0, 8'h00, 0);
        see_ctrl_model_inst.resync();
        wr(10'h050, 1, 0, 8'h22, 1'b0, 1'b0);
        chk(10'h050, 1, 8'h22, 1);
    endtask
    task automatic s_glitch();
        wr(10'h160, 2, 0, 8'hC3, 1'b1, 1'b0);
        chk(10'h160, 2, 8'hC3, 2);
    endtask
    task automatic s_lowvcc();
        low_vcc_in = 1'b1;
        wr(10'h2E0, 2, 0, 8'h66, 1'b0, 1'b0);
        chk(10'h2E0, 0, 8'h00, 0);
        low_vcc_in = 1'b0;
    endtask
    initial begin
        repeat (8) @(negedge clk_in);
        rst_in = 1'b0;
        s_init();
        s_page();
        s_partial();
        s_wrap();
        s_abort();
        s_glitch();
        s_lowvcc();
        tally_and_finish();
    end
endmodule
